// >>> verilog/dma_geom_defs.svh
// Register map, field positions and widths of the DMA geometry block
`ifndef DMA_GEOM_DEFS_SVH
`define DMA_GEOM_DEFS_SVH

`define DG_NUM_CHAN      4
`define DG_ADR_W         8
`define DG_DAT_W         32
`define DG_SEL_W         4
`define DG_CHAN_LSB      6
`define DG_REG_MSB       5
`define DG_REG_LSB       2
`define DG_REG_W         4

`define DG_REG_CTRL      4'h0
`define DG_REG_SSA       4'h1
`define DG_REG_DSA       4'h2
`define DG_REG_SSIZ      4'h3
`define DG_REG_DSIZ      4'h4
`define DG_REG_SPTR      4'h5
`define DG_REG_DPTR      4'h6
`define DG_REG_STAT      4'h7
`define DG_REG_MASK      4'h8

`define DG_CTRL_START    0
`define DG_CTRL_ABORT    1
`define DG_CTRL_BUSY     0

`define DG_EV_W          5
`define DG_EV_SRC_DONE   0
`define DG_EV_SRC_HALF   1
`define DG_EV_DST_DONE   2
`define DG_EV_DST_HALF   3
`define DG_EV_BLOCK      4

`define DG_ADDR_W        32
`define DG_SIZE_W        16
`define DG_PTR_W         17
`define DG_SIZE_FULL     17'h10000

`endif

// >>> verilog/dma_geom_pkg.sv
// Shared types of the DMA geometry block
`include "dma_geom_defs.svh"

package dma_geom_pkg;

  typedef struct packed {
    logic [`DG_ADDR_W-1:0] src_start_addr;
    logic [`DG_ADDR_W-1:0] dst_start_addr;
    logic [`DG_SIZE_W-1:0] src_size_bytes;
    logic [`DG_SIZE_W-1:0] dst_size_bytes;
  } chan_cfg_t;

  typedef struct packed {
    logic                  xfer_req;
    logic [`DG_ADDR_W-1:0] src_addr;
    logic [`DG_ADDR_W-1:0] dst_addr;
  } chan_bus_t;

  typedef struct packed {
    logic                  active;
    logic [`DG_SIZE_W-1:0] src_byte_pointer;
    logic [`DG_SIZE_W-1:0] dst_byte_pointer;
  } walk_stat_t;

endpackage

// >>> verilog/chan_walker.sv
// One channel's byte walker: pointers, bus addresses and size events
`timescale 1ns/1ps
`include "dma_geom_defs.svh"

module chan_walker (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire dma_geom_pkg::chan_cfg_t   cfg,
  input  wire logic                      start,
  input  wire logic                      abort,
  input  wire logic                      xfer_ack,
  output      dma_geom_pkg::chan_bus_t   bus,
  output      dma_geom_pkg::walk_stat_t  stat,
  output      logic [`DG_EV_W-1:0]       events
);

  typedef struct packed {
    dma_geom_pkg::chan_bus_t bus;
    logic [`DG_PTR_W-1:0]    sptr;
    logic [`DG_PTR_W-1:0]    dptr;
    logic [`DG_PTR_W-1:0]    moved;
    logic [`DG_EV_W-1:0]     ev;
  } walk_t;

  walk_t walk_r;
  walk_t walk_nxt;

  // Zero encodes the full 64 KiB span
  function automatic logic [`DG_PTR_W-1:0] span(
    input logic [`DG_SIZE_W-1:0] sz
  );
    if (sz == '0)
      return `DG_SIZE_FULL;
    return {1'b0, sz};
  endfunction

  always_comb begin
    logic [`DG_PTR_W-1:0] ssz;
    logic [`DG_PTR_W-1:0] dsz;
    logic [`DG_PTR_W-1:0] sp;
    logic [`DG_PTR_W-1:0] dp;
    logic [`DG_PTR_W-1:0] mv;
    ssz      = span(cfg.src_size_bytes);
    dsz      = span(cfg.dst_size_bytes);
    sp       = walk_r.sptr + 1'b1;
    dp       = walk_r.dptr + 1'b1;
    mv       = walk_r.moved + 1'b1;
    walk_nxt = walk_r;
    walk_nxt.ev = '0;
    if (start) begin
      walk_nxt.bus.xfer_req = 1'b1;
      walk_nxt.sptr         = '0;
      walk_nxt.dptr         = '0;
      walk_nxt.moved        = '0;
      walk_nxt.bus.src_addr = cfg.src_start_addr;
      walk_nxt.bus.dst_addr = cfg.dst_start_addr;
    end else if (abort) begin
      walk_nxt.bus.xfer_req = 1'b0;
    end else if (walk_r.bus.xfer_req && xfer_ack) begin
      if (sp == (ssz >> 1))
        walk_nxt.ev[`DG_EV_SRC_HALF] = 1'b1;
      if (dp == (dsz >> 1))
        walk_nxt.ev[`DG_EV_DST_HALF] = 1'b1;
      // Pointers wrap so the shorter side repeats its span
      if (sp == ssz) begin
        walk_nxt.ev[`DG_EV_SRC_DONE] = 1'b1;
        sp = '0;
      end
      if (dp == dsz) begin
        walk_nxt.ev[`DG_EV_DST_DONE] = 1'b1;
        dp = '0;
      end
      if (mv == ((ssz > dsz) ? ssz : dsz)) begin
        walk_nxt.ev[`DG_EV_BLOCK] = 1'b1;
        walk_nxt.bus.xfer_req     = 1'b0;
      end
      walk_nxt.sptr  = sp;
      walk_nxt.dptr  = dp;
      walk_nxt.moved = mv;
      // Start address used as is: no translation here
      walk_nxt.bus.src_addr = cfg.src_start_addr
                              + {{(`DG_ADDR_W-`DG_PTR_W){1'b0}}, sp};
      walk_nxt.bus.dst_addr = cfg.dst_start_addr
                              + {{(`DG_ADDR_W-`DG_PTR_W){1'b0}}, dp};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      walk_r <= '0;
    else
      walk_r <= walk_nxt;
  end

  assign bus                   = walk_r.bus;
  assign events                = walk_r.ev;
  assign stat.active           = walk_r.bus.xfer_req;
  assign stat.src_byte_pointer = walk_r.sptr[`DG_SIZE_W-1:0];
  assign stat.dst_byte_pointer = walk_r.dptr[`DG_SIZE_W-1:0];

endmodule

// >>> verilog/irq_flags.sv
// Sticky event flags, masks and the shared interrupt level
`timescale 1ns/1ps
`include "dma_geom_defs.svh"

module irq_flags #(
  parameter int NUM_CHAN = `DG_NUM_CHAN
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_b,
  input  wire logic [NUM_CHAN*`DG_EV_W-1:0] events,
  input  wire logic [NUM_CHAN-1:0]          clr_we,
  input  wire logic [NUM_CHAN-1:0]          mask_we,
  input  wire logic [`DG_EV_W-1:0]          wdat,
  output      logic [NUM_CHAN*`DG_EV_W-1:0] status,
  output      logic [NUM_CHAN*`DG_EV_W-1:0] mask,
  output      logic                         irq
);

  typedef struct packed {
    logic [NUM_CHAN*`DG_EV_W-1:0] stat;
    logic [NUM_CHAN*`DG_EV_W-1:0] mask;
    logic                         irq;
  } flags_t;

  flags_t flags_r;
  flags_t flags_nxt;

  always_comb begin
    flags_nxt = flags_r;
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (clr_we[c])
        flags_nxt.stat[c*`DG_EV_W +: `DG_EV_W] =
          flags_r.stat[c*`DG_EV_W +: `DG_EV_W] & ~wdat;
      if (mask_we[c])
        flags_nxt.mask[c*`DG_EV_W +: `DG_EV_W] = wdat;
    end
    // New events win over a clear in the same cycle
    flags_nxt.stat = flags_nxt.stat | events;
    flags_nxt.irq  = |(flags_nxt.stat & flags_nxt.mask);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  assign status = flags_r.stat;
  assign mask   = flags_r.mask;
  assign irq    = flags_r.irq;

endmodule

// >>> verilog/dma_geom_regs.sv
// DMA channel geometry registers behind a classic Wishbone slave
//
// Functional notes
// - Each channel keeps a 32-bit RW source start, zero at reset.
// - Each channel keeps a 32-bit RW destination start, zero at reset.
// - Source size is 16 RW bits; N means N bytes, zero means 65,536 bytes.
// - Destination size is 16 RW bits; N means N bytes, zero means 65,536.
// - Bits 31 to 16 of both size registers ignore writes and read as zero.
// - Source done fires at pointer equal to size, source half at half size.
// - Block complete fires once the larger of the two sizes has been moved.
`timescale 1ns/1ps
`include "dma_geom_defs.svh"

module dma_geom_regs #(
  parameter int NUM_CHAN = `DG_NUM_CHAN,
  parameter int ADR_W    = `DG_ADR_W
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_b,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [ADR_W-1:0]             wb_adr_i,
  input  wire logic [`DG_SEL_W-1:0]         wb_sel_i,
  input  wire logic [`DG_DAT_W-1:0]         wb_dat_i,
  output      logic [`DG_DAT_W-1:0]         wb_dat_o,
  output      logic                         wb_ack_o,
  input  wire logic [NUM_CHAN-1:0]          xfer_ack,
  output      dma_geom_pkg::chan_bus_t [NUM_CHAN-1:0] chan_bus,
  output      logic                         irq
);

  localparam int CHAN_W = ADR_W - `DG_CHAN_LSB;

  typedef struct packed {
    dma_geom_pkg::chan_cfg_t [NUM_CHAN-1:0] cfg;
    logic [NUM_CHAN-1:0]                    start;
    logic [NUM_CHAN-1:0]                    abort;
    logic [NUM_CHAN-1:0]                    clr_we;
    logic [NUM_CHAN-1:0]                    mask_we;
    logic [`DG_EV_W-1:0]                    wdat;
    logic                                   ack;
    logic [`DG_DAT_W-1:0]                   dat;
  } regs_t;

  regs_t regs_r;
  regs_t regs_nxt;

  dma_geom_pkg::walk_stat_t [NUM_CHAN-1:0] walk_stat;
  logic [NUM_CHAN*`DG_EV_W-1:0]            events;
  logic [NUM_CHAN*`DG_EV_W-1:0]            status;
  logic [NUM_CHAN*`DG_EV_W-1:0]            mask;

  // Byte lanes not selected keep their old contents
  function automatic logic [`DG_DAT_W-1:0] merge_sel(
    input logic [`DG_DAT_W-1:0] old,
    input logic [`DG_DAT_W-1:0] wdat,
    input logic [`DG_SEL_W-1:0] sel
  );
    logic [`DG_DAT_W-1:0] res;
    res = old;
    for (int b = 0; b < `DG_SEL_W; b++) begin
      if (sel[b])
        res[b*8 +: 8] = wdat[b*8 +: 8];
    end
    return res;
  endfunction

  // Channel index from the address, out of range when too large
  function automatic logic chan_hit(
    input logic [ADR_W-1:0] adr,
    input int               c
  );
    return adr[ADR_W-1:`DG_CHAN_LSB] == CHAN_W'(c);
  endfunction

  function automatic logic [`DG_DAT_W-1:0] zext16(
    input logic [`DG_SIZE_W-1:0] v
  );
    return {{(`DG_DAT_W-`DG_SIZE_W){1'b0}}, v};
  endfunction

  function automatic logic [`DG_DAT_W-1:0] zext_ev(
    input logic [`DG_EV_W-1:0] v
  );
    return {{(`DG_DAT_W-`DG_EV_W){1'b0}}, v};
  endfunction

  always_comb begin
    logic                   take;
    logic [`DG_REG_W-1:0]   sel_reg;
    logic [`DG_DAT_W-1:0]   merged;
    logic [`DG_DAT_W-1:0]   rd;
    logic [`DG_DAT_W-1:0]   old;
    take     = wb_cyc_i && wb_stb_i && !regs_r.ack;
    sel_reg  = wb_adr_i[`DG_REG_MSB:`DG_REG_LSB];
    merged   = '0;
    old      = '0;
    rd       = '0;
    regs_nxt = regs_r;
    regs_nxt.start   = '0;
    regs_nxt.abort   = '0;
    regs_nxt.clr_we  = '0;
    regs_nxt.mask_we = '0;
    regs_nxt.wdat    = wb_dat_i[`DG_EV_W-1:0];
    // Ack drops the cycle after it was given
    regs_nxt.ack     = take;
    if (take) begin
      regs_nxt.dat = '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (chan_hit(wb_adr_i, c)) begin
          case (sel_reg)
            `DG_REG_CTRL: begin
              rd = {{(`DG_DAT_W-1){1'b0}}, walk_stat[c].active};
              if (wb_we_i && wb_sel_i[0]) begin
                regs_nxt.start[c] = wb_dat_i[`DG_CTRL_START];
                // Abort loses to a start written together
                regs_nxt.abort[c] = wb_dat_i[`DG_CTRL_ABORT]
                                    && !wb_dat_i[`DG_CTRL_START];
              end
            end
            `DG_REG_SSA: begin
              old = regs_r.cfg[c].src_start_addr;
              rd  = old;
              merged = merge_sel(old, wb_dat_i, wb_sel_i);
              if (wb_we_i)
                regs_nxt.cfg[c].src_start_addr = merged;
            end
            `DG_REG_DSA: begin
              old = regs_r.cfg[c].dst_start_addr;
              rd  = old;
              merged = merge_sel(old, wb_dat_i, wb_sel_i);
              if (wb_we_i)
                regs_nxt.cfg[c].dst_start_addr = merged;
            end
            `DG_REG_SSIZ: begin
              old = zext16(regs_r.cfg[c].src_size_bytes);
              rd  = old;
              merged = merge_sel(old, wb_dat_i, wb_sel_i);
              if (wb_we_i)
                regs_nxt.cfg[c].src_size_bytes =
                  merged[`DG_SIZE_W-1:0];
            end
            `DG_REG_DSIZ: begin
              old = zext16(regs_r.cfg[c].dst_size_bytes);
              rd  = old;
              merged = merge_sel(old, wb_dat_i, wb_sel_i);
              if (wb_we_i)
                regs_nxt.cfg[c].dst_size_bytes =
                  merged[`DG_SIZE_W-1:0];
            end
            `DG_REG_SPTR: begin
              rd = zext16(walk_stat[c].src_byte_pointer);
            end
            `DG_REG_DPTR: begin
              rd = zext16(walk_stat[c].dst_byte_pointer);
            end
            `DG_REG_STAT: begin
              rd = zext_ev(status[c*`DG_EV_W +: `DG_EV_W]);
              if (wb_we_i && wb_sel_i[0])
                regs_nxt.clr_we[c] = 1'b1;
            end
            `DG_REG_MASK: begin
              rd = zext_ev(mask[c*`DG_EV_W +: `DG_EV_W]);
              if (wb_we_i && wb_sel_i[0])
                regs_nxt.mask_we[c] = 1'b1;
            end
            default: begin
              rd = '0;
            end
          endcase
          if (!wb_we_i)
            regs_nxt.dat = rd;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      regs_r <= '0;
    else
      regs_r <= regs_nxt;
  end

  assign wb_ack_o = regs_r.ack;
  assign wb_dat_o = regs_r.dat;

  // One walker per channel, each fed only its own geometry
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    chan_walker u_walker (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .cfg      (regs_r.cfg[g]),
      .start    (regs_r.start[g]),
      .abort    (regs_r.abort[g]),
      .xfer_ack (xfer_ack[g]),
      .bus      (chan_bus[g]),
      .stat     (walk_stat[g]),
      .events   (events[g*`DG_EV_W +: `DG_EV_W])
    );
  end

  irq_flags #(
    .NUM_CHAN (NUM_CHAN)
  ) u_irq (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .events  (events),
    .clr_we  (regs_r.clr_we),
    .mask_we (regs_r.mask_we),
    .wdat    (regs_r.wdat),
    .status  (status),
    .mask    (mask),
    .irq     (irq)
  );

endmodule

// >>> verif/dma_geom_regs_asserts.sv
// Port checker for the geometry register block, bound below
`timescale 1ns/1ps
`include "dma_geom_defs.svh"

module dma_geom_regs_asserts #(
  parameter int NUM_CHAN = `DG_NUM_CHAN,
  parameter int ADR_W    = `DG_ADR_W
) (
  input wire logic                  clk_sys,
  input wire logic                  rst_b,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [`DG_DAT_W-1:0]  wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic [NUM_CHAN-1:0]   xfer_ack,
  input wire dma_geom_pkg::chan_bus_t [NUM_CHAN-1:0] chan_bus,
  input wire logic                  irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic go  = chan_bus[0].xfer_req;

  a_ack_one_shot: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_on_req: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_write_data_zero: assert property (
    wb_ack_o && $past(wb_we_i) |-> wb_dat_o == '0)
    else $error("write cycle returned data");
  a_addr_hold: assert property (go && !xfer_ack[0] && !req |=>
    $stable(chan_bus[0].src_addr) && $stable(chan_bus[0].dst_addr))
    else $error("bus address moved without a byte");
  a_run_needs_cmd: assert property ($rose(go) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("channel started without a command");
  a_end_on_byte: assert property ($fell(go) |-> $past(xfer_ack[0]))
    else $error("block ended without a moved byte");
  a_irq_rise_cause: assert property ($rose(irq) |->
    $past(|xfer_ack, 2) || $past(|xfer_ack, 3) || $past(|xfer_ack, 4) ||
    $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("irq rose without cause");
  a_irq_fall_cause: assert property ($fell(irq) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("irq fell without a register write");

  c_write: cover property (req && wb_we_i ##1 wb_ack_o);
  c_run: cover property ($rose(go));
  c_irq: cover property ($rose(irq));
endmodule

bind dma_geom_regs dma_geom_regs_asserts #(
  .NUM_CHAN(NUM_CHAN),
  .ADR_W(ADR_W)
) u_chk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .xfer_ack(xfer_ack),
  .chan_bus(chan_bus),
  .irq(irq)
);

// >>> verif/mem_partner.sv
// Memory side model that answers channel byte requests
`timescale 1ns/1ps

module mem_partner #(
  parameter int NUM_CHAN = 4
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic [NUM_CHAN-1:0] xfer_req,
  input  wire logic                slow,
  output      logic [NUM_CHAN-1:0] xfer_ack
);
  logic [1:0] cnt_r;

  // Slow mode stalls two cycles of three to stretch each block
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r    <= 2'h0;
      xfer_ack <= '0;
    end else begin
      cnt_r    <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
      xfer_ack <= (slow && cnt_r != 2'h0) ? '0 : xfer_req;
    end
  end
endmodule

// >>> verif/dma_geom_regs_tb_top.sv
// Self-checking bench for the geometry register block
`timescale 1ns/1ps
`include "dma_geom_defs.svh"

module dma_geom_regs_tb_top;
  logic        clk_sys  = 1'b0;
  logic        rst_b    = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        slow     = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq;
  logic [3:0]  xfer_ack;
  logic [31:0] q;
  dma_geom_pkg::chan_bus_t [3:0] chan_bus;
  int          n_fail    = 0;
  int          tests_run = 0;

  always #25 clk_sys = ~clk_sys;

  dma_geom_regs #(.NUM_CHAN(4), .ADR_W(8)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .xfer_ack(xfer_ack), .chan_bus(chan_bus),
    .irq(irq));
  mem_partner #(.NUM_CHAN(4)) u_mem (
    .clk_sys(clk_sys), .rst_b(rst_b), .xfer_req({chan_bus[3].xfer_req,
    chan_bus[2].xfer_req, chan_bus[1].xfer_req, chan_bus[0].xfer_req}),
    .slow(slow), .xfer_ack(xfer_ack));

  task wrap_up;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  function logic [7:0] ra(input int c, input logic [3:0] i);
    return {c[1:0], i, 2'b00};
  endfunction

  function int sz(input logic [15:0] v);
    return (v == 16'h0) ? 65536 : int'(v);
  endfunction

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: no ack", $time);
      wrap_up;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task wr(input int c, input logic [3:0] i, input logic [31:0] d);
    bus(1'b1, ra(c, i), d, 4'hF);
  endtask

  task rc(input int c, input logic [3:0] i, input logic [31:0] e);
    bus(1'b0, ra(c, i), 32'h0, 4'hF);
    chk(q, e);
  endtask

  task t_reset_vals;
    for (int c = 0; c < 4; c++) begin
      for (int i = 1; i < 5; i++) begin
        rc(c, 4'(i), 32'h0);
      end
    end
  endtask

  task t_own_copy;
    for (int c = 0; c < 4; c++) begin
      wr(c, `DG_REG_SSA, 32'hA000_0000 | c);
      wr(c, `DG_REG_DSA, 32'h5A5A_0000 | c);
      wr(c, `DG_REG_SSIZ, 32'hFFFF_1230 | c);
      wr(c, `DG_REG_DSIZ, 32'hDEAD_0040 | c);
    end
    for (int c = 0; c < 4; c++) begin
      rc(c, `DG_REG_SSA, 32'hA000_0000 | c);
      rc(c, `DG_REG_DSA, 32'h5A5A_0000 | c);
      rc(c, `DG_REG_SSIZ, 32'h0000_1230 | c);
      rc(c, `DG_REG_DSIZ, 32'h0000_0040 | c);
    end
    bus(1'b1, ra(0, `DG_REG_SSA), 32'hAABB_CCDD, 4'h2);
    rc(0, `DG_REG_SSA, 32'hA000_CC00);
    wr(0, 4'hF, 32'hFFFF_FFFF);
    rc(0, 4'hF, 32'h0);
  endtask

  // Physical addresses only: the walker adds pointers untranslated
  task t_run(input int c, input logic [31:0] s, input logic [31:0] d,
             input logic [15:0] ss, input logic [15:0] ds, input logic sl);
    int k;
    int n;
    slow <= sl;
    wr(c, `DG_REG_SSA, s);
    wr(c, `DG_REG_DSA, d);
    wr(c, `DG_REG_SSIZ, {16'h0, ss});
    wr(c, `DG_REG_DSIZ, {16'h0, ds});
    wr(c, `DG_REG_MASK, 32'h0);
    wr(c, `DG_REG_CTRL, 32'h1);
    k = 0;
    n = 0;
    while (chan_bus[c].xfer_req !== 1'b1 && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    while (chan_bus[c].xfer_req === 1'b1 && n < 70000) begin
      if (xfer_ack[c] === 1'b1) begin
        chk(chan_bus[c].src_addr, s + 32'(k % sz(ss)));
        chk(chan_bus[c].dst_addr, d + 32'(k % sz(ds)));
        k++;
      end
      @(negedge clk_sys);
      n++;
    end
    if (chan_bus[c].xfer_req !== 1'b0) begin
      n_fail++;
      $display("unexpected at %0t: block never ended", $time);
      wrap_up;
    end
    chk(k, (sz(ss) > sz(ds)) ? sz(ss) : sz(ds));
    repeat (4) @(posedge clk_sys);
    rc(c, `DG_REG_STAT, 32'h1F);
    chk(irq, 1'b0);
    wr(c, `DG_REG_MASK, 32'h1F);
    repeat (3) @(negedge clk_sys);
    chk(irq, 1'b1);
    wr(c, `DG_REG_STAT, 32'h1F);
    repeat (3) @(negedge clk_sys);
    chk(irq, 1'b0);
    rc(c, `DG_REG_STAT, 32'h0);
  endtask

  // Abort mid-block: pointers freeze, addresses stay start plus pointer
  task t_abort;
    logic [31:0] p;
    wr(1, `DG_REG_SSA, 32'h6000_0000);
    wr(1, `DG_REG_DSA, 32'h7000_0000);
    wr(1, `DG_REG_SSIZ, 32'h0);
    wr(1, `DG_REG_DSIZ, 32'h0);
    wr(1, `DG_REG_CTRL, 32'h1);
    rc(1, `DG_REG_CTRL, 32'h1);
    wr(1, `DG_REG_CTRL, 32'h2);
    rc(1, `DG_REG_CTRL, 32'h0);
    bus(1'b0, ra(1, `DG_REG_SPTR), 32'h0, 4'hF);
    p = q;
    chk(32'(p != 32'h0 && p < 32'h40), 32'h1);
    rc(1, `DG_REG_DPTR, p);
    rc(1, `DG_REG_SPTR, p);
    chk(chan_bus[1].src_addr, 32'h6000_0000 + p);
    chk(chan_bus[1].dst_addr, 32'h7000_0000 + p);
    rc(1, `DG_REG_STAT, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset_vals;
    t_own_copy;
    t_run(0, 32'h1000_0000, 32'h2000_0000, 16'h5, 16'h3, 1'b0);
    t_run(3, 32'h0000_FFFE, 32'h3000_0100, 16'h2, 16'h8, 1'b1);
    t_run(2, 32'h4000_0000, 32'h5000_0000, 16'h0, 16'h0, 1'b0);
    t_abort;
    wrap_up;
  end
endmodule
